// file: hw/pio_map.vh
// register map, field masks and reset values of the port pin control block
// Contract
// - every configuration register except pin input accepts writes at any time
// - an enabled pull-up stays off while the pin drives push-pull output
// - unimplemented bit positions of any port register read as zero
// - the input register returns the pin level, except on analog-shared pins with digital input enable clear
// - with direction set to input, data register reads return the input register value (pin level, gated on analog-shared pins)
// - an enabled peripheral function overrides the general-purpose direction setting
// - several peripherals enabled on one pin: highest fixed-rank module wins
// - forced-output peripheral functions drive the pin and force pull devices off
// - the SPI function sets pin direction; pulls off only while it drives
// - enabled DAC buffer output: analog output, digital driver off, pulls off
// - analog-shared pins pass digital input only with digital input enable set
// - per-port implemented bit ranges, wired-or on S and J, reduced drive P odd
// - port L implements only bit 0 of input, polarity, irq and input-enable
`ifndef PIO_MAP_VH
`define PIO_MAP_VH

// ****************************************************************
// address layout: byte address = port * stride + register * 4
// ****************************************************************
`define PIO_PORT_STRIDE   12'h040
`define PIO_NUM_PORTS     8
`define PIO_NUM_REGS      4'ha
`define PIO_REG_DATA      4'h0
`define PIO_REG_INPUT     4'h1
`define PIO_REG_DIR       4'h2
`define PIO_REG_PULL_EN   4'h3
`define PIO_REG_POLARITY  4'h4
`define PIO_REG_IRQ_EN    4'h5
`define PIO_REG_IRQ_FLAG  4'h6
`define PIO_REG_DIG_IN_EN 4'h7
`define PIO_REG_RED_DRV   4'h8
`define PIO_REG_WIRED_OR  4'h9

// ****************************************************************
// implemented bits, 8 per port, port 0 lowest: e adh adl t s p j l
// ****************************************************************
`define PIO_MASK_DATA     64'h0003ff0fffff0303
`define PIO_MASK_INPUT    64'h0103ff0fffff0303
`define PIO_MASK_DIR      64'h0003ff0fffff0303
`define PIO_MASK_PULL_EN  64'h0003ff0fffff0303
`define PIO_MASK_POLARITY 64'h0103ff0fffff0303
`define PIO_MASK_IRQ      64'h0100ff0f00ff0300
`define PIO_MASK_DIG_IN   64'h0100000000ff0300
`define PIO_MASK_RED_DRV  64'h0000aa0000000000
`define PIO_MASK_WIRED_OR 64'h0003000f00000000

// ****************************************************************
// reset values and bus answers
// ****************************************************************
`define PIO_RST_BYTE      8'h00
`define PIO_RESP_OKAY     2'b00
`define PIO_RESP_SLVERR   2'b10

`endif

// file: hw/pio_port_regs.v
// register bank of one port with implemented-bit masks and edge flags
`timescale 1ns/10ps
module pio_port_regs #(
   parameter [7:0] M_DATA  = 8'hff,
   parameter [7:0] M_INPUT = 8'hff,
   parameter [7:0] M_DIR   = 8'hff,
   parameter [7:0] M_PULL  = 8'hff,
   parameter [7:0] M_POL   = 8'hff,
   parameter [7:0] M_IRQ   = 8'hff,
   parameter [7:0] M_DIE   = 8'hff,
   parameter [7:0] M_RED   = 8'hff,
   parameter [7:0] M_WIRED = 8'hff
) (
   input  wire       aclk,
   input  wire       aresetn,
   input  wire       wr_en,
   input  wire [3:0] wr_sel,
   input  wire [7:0] wr_data,
   input  wire [3:0] rd_sel,
   input  wire [7:0] pin_level,
   output reg  [7:0] rd_data,
   output wire [7:0] dig_in,
   output wire [7:0] data_q,
   output wire [7:0] dir_q,
   output wire [7:0] pull_en_q,
   output wire [7:0] pol_q,
   output wire [7:0] red_drv_q,
   output wire [7:0] wired_or_q
);
`include "pio_map.vh"

   reg [7:0] data_r_q, dir_r_q, pull_r_q, pol_r_q, ie_q, flag_q, die_q, red_q, wired_q;
   reg [7:0] prev_q;
   wire [7:0] rise;
   wire [7:0] fall;
   wire [7:0] edge_hit;
   wire [7:0] flag_d;

   // digital path gated where the pin shares an analog function
   assign dig_in = pin_level & M_INPUT & (~M_DIE | die_q);
   assign rise = dig_in & ~prev_q;
   assign fall = ~dig_in & prev_q;
   // polarity one selects rising edge
   assign edge_hit = ((rise & pol_r_q) | (fall & ~pol_r_q)) & M_IRQ;
   // write one clears, but a fresh edge in the same cycle wins
   assign flag_d = (flag_q & ~((wr_en && wr_sel == `PIO_REG_IRQ_FLAG) ? wr_data : 8'h00)) | edge_hit;

   // masked storage; unimplemented bits can never become one
   always @(posedge aclk) begin
      if (!aresetn) begin
         data_r_q <= `PIO_RST_BYTE;
         dir_r_q  <= `PIO_RST_BYTE;
         pull_r_q <= `PIO_RST_BYTE;
         pol_r_q  <= `PIO_RST_BYTE;
         ie_q     <= `PIO_RST_BYTE;
         flag_q   <= `PIO_RST_BYTE;
         die_q    <= `PIO_RST_BYTE;
         red_q    <= `PIO_RST_BYTE;
         wired_q  <= `PIO_RST_BYTE;
         prev_q   <= `PIO_RST_BYTE;
      end else begin
         prev_q <= dig_in;
         flag_q <= flag_d & M_IRQ;
         if (wr_en) begin
            case (wr_sel)
               `PIO_REG_DATA:      data_r_q <= wr_data & M_DATA;
               `PIO_REG_DIR:       dir_r_q  <= wr_data & M_DIR;
               `PIO_REG_PULL_EN:   pull_r_q <= wr_data & M_PULL;
               `PIO_REG_POLARITY:  pol_r_q  <= wr_data & M_POL;
               `PIO_REG_IRQ_EN:    ie_q     <= wr_data & M_IRQ;
               `PIO_REG_DIG_IN_EN: die_q    <= wr_data & M_DIE;
               `PIO_REG_RED_DRV:   red_q    <= wr_data & M_RED;
               `PIO_REG_WIRED_OR:  wired_q  <= wr_data & M_WIRED;
               default:            ; // input register holds; flags clear through flag_d
            endcase
         end
      end
   end

   // read mux; input bits in data register follow the gated digital input (dig_in) when direction is input
   always @* begin
      case (rd_sel)
         `PIO_REG_DATA:      rd_data = ((data_r_q & dir_r_q) | (dig_in & ~dir_r_q)) & M_DATA;
         `PIO_REG_INPUT:     rd_data = dig_in;
         `PIO_REG_DIR:       rd_data = dir_r_q;
         `PIO_REG_PULL_EN:   rd_data = pull_r_q;
         `PIO_REG_POLARITY:  rd_data = pol_r_q;
         `PIO_REG_IRQ_EN:    rd_data = ie_q;
         `PIO_REG_IRQ_FLAG:  rd_data = flag_q;
         `PIO_REG_DIG_IN_EN: rd_data = die_q;
         `PIO_REG_RED_DRV:   rd_data = red_q;
         `PIO_REG_WIRED_OR:  rd_data = wired_q;
         default:            rd_data = 8'h00;
      endcase
   end

   assign data_q     = data_r_q;
   assign dir_q      = dir_r_q;
   assign pull_en_q  = pull_r_q;
   assign pol_q      = pol_r_q;
   assign red_drv_q  = red_q;
   assign wired_or_q = wired_q;

endmodule // pio_port_regs

// file: hw/pio_pin_cell.v
// per-pin override of direction and pull devices by shared functions
`timescale 1ns/10ps
module pio_pin_cell #(
   parameter IMPL = 1
) (
   input  wire gp_data,
   input  wire gp_dir,
   input  wire gp_pull_en,
   input  wire gp_pol,
   input  wire gp_wired_or,
   input  wire gp_red_drv,
   input  wire osc_en,
   input  wire dac_en,
   input  wire i2c_en,
   input  wire i2c_data,
   input  wire spi_en,
   input  wire spi_drive,
   input  wire spi_data,
   input  wire fout_en,
   input  wire fout_data,
   input  wire fin_en,
   input  wire fin_pd_off,
   output reg  pin_out,
   output reg  pin_oe,
   output reg  pull_up,
   output reg  pull_down,
   output reg  analog_out,
   output wire red_drv
);

   reg gp_pu;
   reg gp_pd;

   // fixed rank: oscillator, dac, i2c, spi, forced output, forced input, gpio
   always @* begin
      gp_pu      = gp_pull_en & ~gp_pol;
      gp_pd      = gp_pull_en & gp_pol;
      pin_out    = 1'b0;
      pin_oe     = 1'b0;
      pull_up    = 1'b0;
      pull_down  = 1'b0;
      analog_out = 1'b0;
      if (IMPL == 0) begin
         pin_oe = 1'b0;
      end else if (osc_en) begin
         pin_oe = 1'b0;
      end else if (dac_en) begin
         analog_out = 1'b1;
      end else if (i2c_en) begin
         pin_oe  = ~i2c_data;
         pull_up = gp_pu;
      end else if (spi_en) begin
         pin_oe    = spi_drive;
         pin_out   = spi_data;
         pull_up   = gp_pu & ~spi_drive;
         pull_down = gp_pd & ~spi_drive;
      end else if (fout_en) begin
         pin_oe  = 1'b1;
         pin_out = fout_data;
      end else if (fin_en) begin
         pull_up   = gp_pu;
         pull_down = gp_pd & ~fin_pd_off;
      end else if (gp_wired_or) begin
         // open-drain keeps its pull-up as the high level source
         pin_oe    = gp_dir & ~gp_data;
         pull_up   = gp_pu;
         pull_down = gp_pd & ~gp_dir;
      end else begin
         pin_oe    = gp_dir;
         pin_out   = gp_data;
         pull_up   = gp_pu & ~gp_dir;
         pull_down = gp_pd & ~gp_dir;
      end
   end

   assign red_drv = (IMPL != 0) & gp_red_drv;

endmodule // pio_pin_cell

// file: hw/pio_top.v
// port pin control with axi4-lite register access
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/10ps
module pio_top (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [11:0] s_axi_awaddr,
   input  wire [2:0]  s_axi_awprot,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output wire [1:0]  s_axi_bresp,
   output wire        s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [11:0] s_axi_araddr,
   input  wire [2:0]  s_axi_arprot,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0]  s_axi_rresp,
   output wire        s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire [63:0] pin_in,
   output wire [63:0] pin_out,
   output wire [63:0] pin_oe,
   output wire [63:0] pin_pull_up,
   output wire [63:0] pin_pull_down,
   output wire [63:0] pin_analog_out,
   output wire [63:0] pin_reduced_drive,
   output wire [63:0] periph_in,
   input  wire [63:0] osc_en,
   input  wire [63:0] dac_en,
   input  wire [63:0] i2c_en,
   input  wire [63:0] i2c_data,
   input  wire [63:0] spi_en,
   input  wire [63:0] spi_drive,
   input  wire [63:0] spi_data,
   input  wire [63:0] fout_en,
   input  wire [63:0] fout_data,
   input  wire [63:0] fin_en,
   input  wire [63:0] fin_pd_off
);
`include "pio_map.vh"

   // ****************************************************************
   // write channel
   // ****************************************************************
   reg         aw_held_q;
   reg  [11:0] aw_addr_q;
   reg         w_held_q;
   reg  [7:0]  w_byte_q;
   reg         w_strb_q;
   reg         bvalid_q;
   reg  [1:0]  bresp_q;
   wire        aw_take;
   wire        w_take;
   wire        do_write;
   wire [2:0]  wr_port;
   wire [3:0]  wr_reg;
   wire        wr_ok;

   assign s_axi_awready = ~aw_held_q & ~bvalid_q;
   assign s_axi_wready  = ~w_held_q & ~bvalid_q;
   assign aw_take       = s_axi_awvalid & s_axi_awready;
   assign w_take        = s_axi_wvalid & s_axi_wready;
   // write happens once both halves are held, in whichever order they came
   assign do_write      = aw_held_q & w_held_q & ~bvalid_q;
   assign wr_port       = aw_addr_q[8:6];
   assign wr_reg        = aw_addr_q[5:2];
   // the input register is read-only; writing it is answered okay and ignored
   assign wr_ok         = (aw_addr_q[11:9] == 3'b000) && (wr_reg < `PIO_NUM_REGS);

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         aw_addr_q <= 12'h000;
         w_held_q  <= 1'b0;
         w_byte_q  <= 8'h00;
         w_strb_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `PIO_RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (w_take) begin
            w_held_q <= 1'b1;
            w_byte_q <= s_axi_wdata[7:0];
            w_strb_q <= s_axi_wstrb[0];
         end
         if (do_write) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= wr_ok ? `PIO_RESP_OKAY : `PIO_RESP_SLVERR;
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp  = bresp_q;

   // ****************************************************************
   // read channel
   // ****************************************************************
   reg         rvalid_q;
   reg  [7:0]  rdata_q;
   reg  [1:0]  rresp_q;
   wire        ar_take;
   wire [2:0]  rd_port;
   wire [3:0]  rd_reg;
   wire        rd_ok;
   wire [63:0] port_rd;

   assign s_axi_arready = ~rvalid_q;
   assign ar_take       = s_axi_arvalid & s_axi_arready;
   assign rd_port       = s_axi_araddr[8:6];
   assign rd_reg        = s_axi_araddr[5:2];
   assign rd_ok         = (s_axi_araddr[11:9] == 3'b000) && (rd_reg < `PIO_NUM_REGS);

   // one-cycle read; data captured so rdata stays stable until taken
   always @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 8'h00;
         rresp_q  <= `PIO_RESP_OKAY;
      end else if (ar_take) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rd_ok ? port_rd[{rd_port, 3'b000} +: 8] : 8'h00;
         rresp_q  <= rd_ok ? `PIO_RESP_OKAY : `PIO_RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata  = {24'h000000, rdata_q};
   assign s_axi_rresp  = rresp_q;

   // ****************************************************************
   // port register banks and pin cells
   // ****************************************************************
   wire [63:0] gp_data;
   wire [63:0] gp_dir;
   wire [63:0] gp_pull;
   wire [63:0] gp_pol;
   wire [63:0] gp_red;
   wire [63:0] gp_wired;

   // a pin exists wherever its input bit is implemented
   localparam [63:0] IMPL_MASK = `PIO_MASK_INPUT;

   genvar p;
   genvar b;
   generate
      for (p = 0; p < `PIO_NUM_PORTS; p = p + 1) begin : g_port
         localparam [63:0] MD = `PIO_MASK_DATA;
         localparam [63:0] MI = `PIO_MASK_INPUT;
         localparam [63:0] MR = `PIO_MASK_DIR;
         localparam [63:0] MP = `PIO_MASK_PULL_EN;
         localparam [63:0] MS = `PIO_MASK_POLARITY;
         localparam [63:0] MQ = `PIO_MASK_IRQ;
         localparam [63:0] ME = `PIO_MASK_DIG_IN;
         localparam [63:0] MV = `PIO_MASK_RED_DRV;
         localparam [63:0] MW = `PIO_MASK_WIRED_OR;
         // per-port implemented ranges come straight from the masks
         pio_port_regs #(
            .M_DATA  (MD[8*p +: 8]),
            .M_INPUT (MI[8*p +: 8]),
            .M_DIR   (MR[8*p +: 8]),
            .M_PULL  (MP[8*p +: 8]),
            .M_POL   (MS[8*p +: 8]),
            .M_IRQ   (MQ[8*p +: 8]),
            .M_DIE   (ME[8*p +: 8]),
            .M_RED   (MV[8*p +: 8]),
            .M_WIRED (MW[8*p +: 8])
         ) u_regs (
            .aclk       (aclk),
            .aresetn    (aresetn),
            .wr_en      (do_write & wr_ok & w_strb_q & (wr_port == p)),
            .wr_sel     (wr_reg),
            .wr_data    (w_byte_q),
            .rd_sel     (rd_reg),
            .pin_level  (pin_in[8*p +: 8]),
            .rd_data    (port_rd[8*p +: 8]),
            .dig_in     (periph_in[8*p +: 8]),
            .data_q     (gp_data[8*p +: 8]),
            .dir_q      (gp_dir[8*p +: 8]),
            .pull_en_q  (gp_pull[8*p +: 8]),
            .pol_q      (gp_pol[8*p +: 8]),
            .red_drv_q  (gp_red[8*p +: 8]),
            .wired_or_q (gp_wired[8*p +: 8])
         );
      end

      // one override cell per pin slot; empty slots stay released
      for (b = 0; b < 64; b = b + 1) begin : g_pin
         pio_pin_cell #(
            .IMPL (IMPL_MASK[b] ? 1 : 0)
         ) u_cell (
            .gp_data     (gp_data[b]),
            .gp_dir      (gp_dir[b]),
            .gp_pull_en  (gp_pull[b]),
            .gp_pol      (gp_pol[b]),
            .gp_wired_or (gp_wired[b]),
            .gp_red_drv  (gp_red[b]),
            .osc_en      (osc_en[b]),
            .dac_en      (dac_en[b]),
            .i2c_en      (i2c_en[b]),
            .i2c_data    (i2c_data[b]),
            .spi_en      (spi_en[b]),
            .spi_drive   (spi_drive[b]),
            .spi_data    (spi_data[b]),
            .fout_en     (fout_en[b]),
            .fout_data   (fout_data[b]),
            .fin_en      (fin_en[b]),
            .fin_pd_off  (fin_pd_off[b]),
            .pin_out     (pin_out[b]),
            .pin_oe      (pin_oe[b]),
            .pull_up     (pin_pull_up[b]),
            .pull_down   (pin_pull_down[b]),
            .analog_out  (pin_analog_out[b]),
            .red_drv     (pin_reduced_drive[b])
         );
      end
   endgenerate

endmodule // pio_top

// file: bench/pio_monitor.sv
// checker of pin override and read-data rules of the port pin block
`timescale 1ns/10ps
`include "pio_map.vh"
module pio_monitor (
   input wire        aclk,
   input wire        aresetn,
   input wire [31:0] s_axi_rdata,
   input wire [1:0]  s_axi_rresp,
   input wire        s_axi_rvalid,
   input wire [63:0] pin_out,
   input wire [63:0] pin_oe,
   input wire [63:0] pin_pull_up,
   input wire [63:0] pin_pull_down,
   input wire [63:0] pin_analog_out,
   input wire [63:0] pin_reduced_drive,
   input wire [63:0] osc_en,
   input wire [63:0] dac_en,
   input wire [63:0] i2c_en,
   input wire [63:0] i2c_data,
   input wire [63:0] spi_en,
   input wire [63:0] spi_drive,
   input wire [63:0] fout_en,
   input wire [63:0] fout_data,
   input wire [63:0] fin_en,
   input wire [63:0] fin_pd_off
);
   // ****************************************************************
   // winning function per slot, fixed rank
   // ****************************************************************
   // rank: osc, dac, i2c, spi, forced output, forced input
   wire [63:0] m     = `PIO_MASK_DIR;
   wire [63:0] w_dac = dac_en & ~osc_en & m;
   wire [63:0] w_i2c = i2c_en & ~osc_en & ~dac_en & m;
   wire [63:0] w_spi = spi_en & ~(osc_en | dac_en | i2c_en) & m;
   wire [63:0] w_fo  = fout_en & ~(osc_en | dac_en | i2c_en | spi_en) & m;
   wire [63:0] w_fi  = fin_en & ~(osc_en | dac_en | i2c_en | spi_en | fout_en) & m;
   wire [63:0] pulls = pin_pull_up | pin_pull_down;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // ****************************************************************
   // assertions
   // ****************************************************************
   a_fout_drive: assert property (((pin_oe & w_fo) == w_fo) && (((pin_out ^ fout_data) & w_fo) == 64'h0))
      else $error("forced output slot not driven with its data");
   a_fout_pull: assert property ((pulls & w_fo) == 64'h0)
      else $error("pull active on forced output slot");
   a_fin_input: assert property ((pin_oe & w_fi) == 64'h0)
      else $error("forced input slot driven");
   a_fin_pd: assert property ((pin_pull_down & w_fi & fin_pd_off) == 64'h0)
      else $error("pull-down active on can receive slot");
   a_spi_dir: assert property ((((pin_oe ^ spi_drive) & w_spi) == 64'h0) && ((pulls & w_spi & spi_drive) == 64'h0))
      else $error("spi slot direction or pull wrong");
   a_dac_analog: assert property ((((pin_analog_out ^ w_dac) & m) == 64'h0) && (((pin_oe | pulls) & w_dac) == 64'h0))
      else $error("dac slot not analog only");
   a_i2c_od: assert property (((pin_oe & w_i2c & i2c_data) == 64'h0) && ((pin_pull_down & w_i2c) == 64'h0))
      else $error("i2c slot drives high or pulls down");
   a_osc_pull: assert property ((pulls & osc_en & m) == 64'h0)
      else $error("pull active on oscillator slot");
   a_slot_inert: assert property (((pin_oe | pin_out) & ~m) == 64'h0)
      else $error("unimplemented slot active");
   a_red_drv: assert property ((pin_reduced_drive & ~`PIO_MASK_RED_DRV) == 64'h0)
      else $error("reduced drive outside its slots");
   a_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("read data above bit 7 not zero");
   a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == `PIO_RESP_SLVERR |-> s_axi_rdata == 32'h0)
      else $error("refused read returned data");
endmodule // pio_monitor

bind pio_top pio_monitor pio_monitor_i (.aclk(aclk), .aresetn(aresetn), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .pin_out(pin_out), .pin_oe(pin_oe),
   .pin_pull_up(pin_pull_up), .pin_pull_down(pin_pull_down), .pin_analog_out(pin_analog_out),
   .pin_reduced_drive(pin_reduced_drive), .osc_en(osc_en), .dac_en(dac_en), .i2c_en(i2c_en),
   .i2c_data(i2c_data), .spi_en(spi_en), .spi_drive(spi_drive), .fout_en(fout_en),
   .fout_data(fout_data), .fin_en(fin_en), .fin_pd_off(fin_pd_off));

// file: bench/pio_pin_model.sv
// model of the external pins: driver, outside source, pulls, floating lines
`timescale 1ns/10ps
module pio_pin_model (
   input  wire        aclk,
   input  wire [63:0] pin_out,
   input  wire [63:0] pin_oe,
   input  wire [63:0] pin_pull_up,
   input  wire [63:0] pin_pull_down,
   input  wire [63:0] ext_drive,
   input  wire [63:0] ext_en,
   output wire [63:0] pin_level
);
   reg  [63:0] last_q = 64'h0;
   wire [63:0] held   = pin_oe | ext_en | pin_pull_up | pin_pull_down;
   // floating line shows the inverse of its last driven level
   assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_drive)
                    | (~pin_oe & ~ext_en & (pin_pull_up | (~pin_pull_down & ~last_q)));
   // only driven levels are kept, so a floating line holds still instead of toggling
   always @(posedge aclk) last_q <= (held & pin_level) | (~held & last_q);
endmodule // pio_pin_model

// file: bench/testbench.sv
// register and pin tests of the port pin block
`timescale 1ns/10ps
`include "pio_map.vh"
module testbench;
   reg         aclk = 1'b0, aresetn = 1'b0;
   reg  [11:0] awaddr = 12'h0, araddr = 12'h0;
   reg  [31:0] wdata = 32'h0;
   reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   wire        awready, wready, bvalid, arready, rvalid;
   wire [1:0]  bresp, rresp;
   wire [31:0] rdata;
   wire [63:0] pin_in, pout, poe, pu, pd, an, rdrv, pin_per;
   reg  [63:0] osc = 0, dac = 0, i2c = 0, i2cd = 0, spi = 0, spid = 0, spix = 0;
   reg  [63:0] fo = 0, fod = 0, fi = 0, fipd = 0, ext = 0, ext_en = 0;
   int         n_mismatch = 0, checks = 0, p, k;
   reg  [1:0]  r;
   reg  [7:0]  d;

   always #10 aclk = ~aclk;

   pio_top pio_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .pin_in(pin_in), .pin_out(pout), .pin_oe(poe), .pin_pull_up(pu),
      .pin_pull_down(pd), .pin_analog_out(an), .pin_reduced_drive(rdrv), .periph_in(pin_per),
      .osc_en(osc), .dac_en(dac), .i2c_en(i2c), .i2c_data(i2cd), .spi_en(spi), .spi_drive(spid),
      .spi_data(spix), .fout_en(fo), .fout_data(fod), .fin_en(fi), .fin_pd_off(fipd));

   pio_pin_model pio_pin_model_i (.aclk(aclk), .pin_out(pout), .pin_oe(poe), .pin_pull_up(pu),
      .pin_pull_down(pd), .ext_drive(ext), .ext_en(ext_en), .pin_level(pin_in));

   // ****************************************************************
   // verdict, compare and bus tasks
   // ****************************************************************
   task close_out;
      begin
         $display("checks %0d mismatches %0d", checks, n_mismatch);
         if (n_mismatch == 0 && checks > 0) $display("NO MISMATCHES");
         else $display("MISMATCHES SEEN");
         $finish;
      end
   endtask

   task chk(input string nm, input [31:0] e, input [31:0] g);
      begin
         checks++;
         if (g !== e) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
         end
      end
   endtask

   // ready sampled at the low phase, acted on at the next rising edge
   task wr(input [11:0] a, input [7:0] v, output [1:0] rs);
      reg ta, tw, tb;
      int n;
      begin
         @(posedge aclk);
         awaddr <= a;
         wdata <= {24'h0, v};
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         n = 0;
         tb = 1'b0;
         while (!tb && n < 100) begin
            @(negedge aclk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tb = bvalid & bready;
            rs = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) bready <= 1'b0;
            n++;
         end
         if (!tb) n_mismatch++;
      end
   endtask

   task rd(input [11:0] a, output [7:0] v, output [1:0] rs);
      reg ta, tr;
      int n;
      begin
         @(posedge aclk);
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
         n = 0;
         tr = 1'b0;
         while (!tr && n < 100) begin
            @(negedge aclk);
            ta = arvalid & arready;
            tr = rvalid & rready;
            v = rdata[7:0];
            rs = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            if (tr) rready <= 1'b0;
            n++;
         end
         if (!tr) n_mismatch++;
      end
   endtask

   function [11:0] ad(input int pn, input int g);
      ad = 12'(pn * 64 + g * 4);
   endfunction

   // implemented bits of register g on port pn
   function [7:0] mb(input int g, input int pn);
      reg [63:0] m;
      case (g)
         1: m = `PIO_MASK_INPUT;
         4: m = `PIO_MASK_POLARITY;
         5, 6: m = `PIO_MASK_IRQ;
         7: m = `PIO_MASK_DIG_IN;
         8: m = `PIO_MASK_RED_DRV;
         9: m = `PIO_MASK_WIRED_OR;
         default: m = `PIO_MASK_DATA;
      endcase
      mb = m[8 * pn +: 8];
   endfunction

   task rchk(input int pn, input int g, input [7:0] e);
      begin
         rd(ad(pn, g), d, r);
         chk("reg read", {24'h0, e}, {24'h0, d});
      end
   endtask

   task do_reset;
      begin
         @(posedge aclk);
         aresetn <= 1'b0;
         repeat (2) @(posedge aclk);
         aresetn <= 1'b1;
      end
   endtask

   // ****************************************************************
   // test sequence
   // ****************************************************************
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      for (p = 0; p < 8; p++) rchk(p, 2, 8'h00);
      // all registers, input included
      for (p = 0; p < 8; p++) for (k = 0; k < 10; k++) begin
         wr(ad(p, k), 8'hff, r);
         chk("write resp", `PIO_RESP_OKAY, r);
      end
      for (p = 0; p < 8; p++) for (k = 0; k < 10; k++) if (k != 1 && k != 6) rchk(p, k, mb(k, p));
      rchk(3, 1, 8'hff);
      chk("reduced drive", 32'haa, {24'h0, rdrv[47:40]});
      wr(12'h200, 8'hff, r);
      chk("bad write resp", `PIO_RESP_SLVERR, r);
      rd(12'h028, d, r);
      chk("bad read resp", `PIO_RESP_SLVERR, r);
      chk("bad read data", 32'h0, {24'h0, d});
      do_reset;
      // port t driven from outside
      ext[31:24] <= 8'h5a;
      ext_en[31:24] <= 8'hff;
      rchk(3, 0, 8'h5a);
      rchk(3, 1, 8'h5a);
      // analog-shared port needs its input enable
      ext[23:16] <= 8'h3c;
      ext_en[23:16] <= 8'hff;
      rchk(2, 1, 8'h00);
      wr(ad(2, 7), 8'hff, r);
      rchk(2, 1, 8'h3c);
      chk("periph in", 32'h3c, {24'h0, pin_per[23:16]});
      // edge flag on port s, rising edge selected, set by a rising edge then cleared by writing one
      wr(ad(4, 4), 8'h01, r);
      ext_en[32] <= 1'b1;
      rchk(4, 6, 8'h00);
      ext[32] <= 1'b1;
      rchk(4, 6, 8'h01);
      wr(ad(4, 6), 8'h01, r);
      rchk(4, 6, 8'h00);
      // pull-up on port p lost once it drives
      wr(ad(5, 3), 8'hff, r);
      chk("pull-up input", 32'hff, {24'h0, pu[47:40]});
      wr(ad(5, 2), 8'hff, r);
      chk("pull-up output", 32'h0, {24'h0, pu[47:40]});
      // stacked functions on port t, routing set
      ext_en[31:24] <= 8'h00;
      wr(ad(3, 2), 8'hff, r);
      wr(ad(3, 3), 8'hff, r);
      wr(ad(3, 4), 8'h09, r);
      fi[31:24] <= 8'hff;
      fipd[31:24] <= 8'hff;
      fo[31:24] <= 8'hf0;
      fod[31:24] <= 8'hff;
      spi[31:24] <= 8'h03;
      spid[31:24] <= 8'h01;
      dac[31:24] <= 8'h80;
      i2c[31:24] <= 8'h04;
      osc[0] <= 1'b1;
      repeat (2) @(posedge aclk);
      chk("oe", 32'h75, {24'h0, poe[31:24]});
      chk("analog", 32'h80, {24'h0, an[31:24]});
      chk("pull-up", 32'h06, {24'h0, pu[31:24]});
      chk("pull-down", 32'h0, {24'h0, pd[31:24]});
      chk("out", 32'h7, {29'h0, pout[30:28]});
      close_out;
   end

   // hang guard
   initial begin
      #(20 * 20000);
      n_mismatch++;
      close_out;
   end
endmodule // testbench
